/* File: rtl/rtiu_pkg.sv */
/*
 Package for the return instruction unit: opcode fields, phase encoding,
 shadow context layout and reset values.
 Assumes the core provides 16-bit instruction words and a 2-bit phase index.
*/
package rtiu_pkg;
    localparam logic [15:0] RFI_OPCODE = 16'h0010;
    localparam logic [15:0] RFI_MASK = 16'hfffe;
    localparam int RFI_RESTORE_BIT = 0;
    localparam logic [7:0] RLW_UPPER = 8'h0c;
    localparam int RLW_UPPER_POS = 8;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam int NUM_SETS = 2;

    typedef struct packed {
        logic [7:0] working;
        logic [7:0] status;
        logic [7:0] bank_select;
        logic [7:0] ptr0_high;
        logic [7:0] ptr0_low;
        logic [7:0] ptr1_high;
        logic [7:0] ptr1_low;
        logic [7:0] ptr2_high;
        logic [7:0] ptr2_low;
        logic [7:0] product_high;
        logic [7:0] product_low;
        logic [7:0] pc_latch_high;
        logic [7:0] pc_latch_upper;
    } rtiu_context_type;

    localparam rtiu_context_type CONTEXT_RESET = '0;
endpackage

/* File: rtl/rtiu_unit.sv */
/*
 Return instruction unit: executes return-from-interrupt and
 return-with-literal. Holds the working register, the restorable context and
 the program counter image.
 Assumes the core supplies the instruction word, phase index, stack top value,
 shadow sets and the context/priority state; the stack itself lives outside.
 The stack pointer and the stack storage stay in the core: this block only
 raises a one-cycle pop strobe and takes the stack top value as it stands.
 The context is kept as an array of byte flip-flops; the core reads it as a
 packed image.
*/
// How it works
// - return-from-interrupt pops the stack and loads stack top into program counter.
// - return-from-interrupt sets the high or low priority global interrupt enable.
// - restore flag 1 copies the shadow context into all shadowed registers.
// - two shadow sets; the current operating state selects which one restores.
// - restore flag 0 leaves every shadowed register unchanged.
// - both returns keep pc_latch_high and pc_latch_upper unless restored from shadow.
// - return-with-literal, upper byte 0000 1100, loads the literal into working_reg.
// - return-with-literal reloads the program counter from the popped stack top.
// - return-from-interrupt updates context state bits, no arithmetic flags.
`timescale 1ns/1ps
`default_nettype none
module rtiu_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Instruction stream
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [1:0] phase,
    // Stack and context state
    input wire logic [20:0] stack_top,
    input wire logic low_context_active,
    input wire logic high_priority_active,
    input wire rtiu_pkg::rtiu_context_type shadow_main,
    input wire rtiu_pkg::rtiu_context_type shadow_low,
    // Core writes into the context when no return runs
    input wire logic ctx_load,
    input wire rtiu_pkg::rtiu_context_type ctx_load_data,
    // Results
    output logic [20:0] program_counter,
    output logic stack_pop,
    output rtiu_pkg::rtiu_context_type context_regs,
    output logic global_int_en_high,
    output logic global_int_en_low,
    output logic low_context_state,
    output logic high_context_state,
    output logic busy
);
    // Number of bytes in one context image
    localparam int CTX_BYTES = $bits(rtiu_pkg::rtiu_context_type) / 8;

    // Program counter image and pop strobe
    logic [20:0] pc_reg;
    logic [20:0] pc_next;
    logic pop_reg;
    logic pop_next;

    // Context bytes, one flip-flop byte per entry
    logic [7:0] ctx_reg [CTX_BYTES];
    wire logic [CTX_BYTES-1:0][7:0] ctx_next;
    wire logic [CTX_BYTES-1:0][7:0] ctx_flat;

    // Enable and context state bits
    logic gie_high_reg;
    logic gie_high_next;
    logic gie_low_reg;
    logic gie_low_next;
    logic low_state_reg;
    logic low_state_next;
    logic high_state_reg;
    logic high_state_next;

    // Second, no-operation cycle of a return
    logic second_cycle_reg;
    logic second_cycle_next;

    // Instruction decode
    wire logic at_q4 = (phase == rtiu_pkg::PHASE_Q4);
    // Decoding is blocked through the next Q4 so the no-operation cycle starts nothing
    wire logic decode_ok = instr_valid && !second_cycle_reg;
    wire logic [15:0] rfi_bits = instr_word & rtiu_pkg::RFI_MASK;
    wire logic [7:0] upper_byte = instr_word[15:rtiu_pkg::RLW_UPPER_POS];
    wire logic [7:0] lit_byte = instr_word[7:0];
    wire logic rfi_match = (rfi_bits == rtiu_pkg::RFI_OPCODE);
    wire logic rlw_match = (upper_byte == rtiu_pkg::RLW_UPPER);
    wire logic is_rfi = decode_ok && rfi_match;
    wire logic is_rlw = decode_ok && rlw_match;
    wire logic restore = instr_word[rtiu_pkg::RFI_RESTORE_BIT];
    wire logic rfi_fire = at_q4 && is_rfi;
    wire logic rlw_fire = at_q4 && is_rlw;
    wire logic exec = rfi_fire || rlw_fire;
    wire logic restore_fire = rfi_fire && restore;
    // A core write during a return would race the restore, so it is dropped
    wire logic load_take = ctx_load && !exec && !second_cycle_reg;

    // Shadow set chosen by the state at execution time
    // The state is sampled at Q4, so a change in that same cycle picks the new set
    wire rtiu_pkg::rtiu_context_type shadow_sel =
        low_context_active ? shadow_low : shadow_main;
    rtiu_pkg::rtiu_context_type literal_ctx;
    wire logic [CTX_BYTES-1:0][7:0] shadow_bytes = shadow_sel;
    wire logic [CTX_BYTES-1:0][7:0] literal_bytes = literal_ctx;
    wire logic [CTX_BYTES-1:0][7:0] load_bytes = ctx_load_data;
    wire rtiu_pkg::rtiu_context_type held_ctx = ctx_flat;

    // Only the working byte takes the literal; the pc latches are kept
    always_comb begin
        literal_ctx = held_ctx;
        literal_ctx.working = lit_byte;
    end

    // Per byte: restore, literal, core load, else hold; flag 0 holds
    // The highest entry is the working byte, entry 0 the upper pc latch
    for (genvar b = 0; b < CTX_BYTES; b++) begin : g_ctx_byte
        assign ctx_next[b] = restore_fire ? shadow_bytes[b]
            : rlw_fire ? literal_bytes[b]
            : load_take ? load_bytes[b]
            : ctx_reg[b];
        assign ctx_flat[b] = ctx_reg[b];

        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                ctx_reg[b] <= rtiu_pkg::BYTE_RESET;
            end else begin
                ctx_reg[b] <= ctx_next[b];
            end
        end
    end

    // Next values
    assign pc_next = exec
        ? stack_top
        : pc_reg;
    assign pop_next = exec;
    assign second_cycle_next = exec ? 1'b1
        : at_q4 ? 1'b0
        : second_cycle_reg;
    assign gie_high_next = (rfi_fire && high_priority_active)
        ? 1'b1
        : gie_high_reg;
    assign gie_low_next = (rfi_fire && !high_priority_active)
        ? 1'b1
        : gie_low_reg;
    // A return from interrupt clears the bit of the level it leaves; no arithmetic flag moves
    assign high_state_next = rfi_fire
        ? (high_priority_active ? 1'b0 : high_state_reg)
        : high_priority_active;
    assign low_state_next = rfi_fire
        ? (high_priority_active ? low_state_reg : 1'b0)
        : low_context_active;

    // Registers, one short process each
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_reg <= rtiu_pkg::PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pop_reg <= 1'b0;
        end else begin
            pop_reg <= pop_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_cycle_reg <= 1'b0;
        end else begin
            second_cycle_reg <= second_cycle_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gie_high_reg <= 1'b0;
        end else begin
            gie_high_reg <= gie_high_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gie_low_reg <= 1'b0;
        end else begin
            gie_low_reg <= gie_low_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_state_reg <= 1'b0;
        end else begin
            low_state_reg <= low_state_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            high_state_reg <= 1'b0;
        end else begin
            high_state_reg <= high_state_next;
        end
    end

    // Outputs straight from the flip-flops
    assign program_counter = pc_reg;
    assign stack_pop = pop_reg;
    assign context_regs = ctx_flat;
    assign global_int_en_high = gie_high_reg;
    assign global_int_en_low = gie_low_reg;
    assign low_context_state = low_state_reg;
    assign high_context_state = high_state_reg;
    assign busy = second_cycle_reg;
endmodule
`default_nettype wire

/* File: testbench/rtiu_properties.sv */
/* Checker for the return instruction unit.
   Assumes the one clock and the phase index that the core drives. */
`timescale 1ns/1ps
`default_nettype none
module rtiu_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Inputs
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [1:0] phase,
    input wire logic [20:0] stack_top,
    input wire logic low_context_active,
    input wire logic high_priority_active,
    input wire rtiu_pkg::rtiu_context_type shadow_main,
    input wire rtiu_pkg::rtiu_context_type shadow_low,
    // Results
    input wire logic [20:0] program_counter,
    input wire logic stack_pop,
    input wire rtiu_pkg::rtiu_context_type context_regs,
    input wire logic global_int_en_high,
    input wire logic global_int_en_low,
    input wire logic busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire go = phase == 2'h3 && instr_valid && !busy;
    wire rfi = go && instr_word[15:1] == 15'h0008;
    wire rlw = go && instr_word[15:8] == 8'h0c;
    wire rtiu_pkg::rtiu_context_type sel = low_context_active ? shadow_low : shadow_main;
    // Second cycle must be a pure no-op
    sequence s_pop;
        stack_pop && busy ##1 (!stack_pop && busy) [*3] ##1 !busy;
    endsequence
    a_rfi_pc: assert property (rfi |=> program_counter == $past(stack_top))
        else $error("pc not loaded on interrupt return");
    a_rfi_gie: assert property (rfi |=>
        ($past(high_priority_active) ? global_int_en_high : global_int_en_low))
        else $error("interrupt enable not set");
    a_restore_set: assert property (rfi && instr_word[0] |=>
        context_regs == $past(sel))
        else $error("wrong shadow set restored");
    a_no_restore: assert property (rfi && !instr_word[0] |=> $stable(context_regs))
        else $error("context changed without restore");
    a_latch_keep: assert property (rlw |=> $stable(context_regs[15:0]))
        else $error("pc latches changed");
    a_rlw_work: assert property (rlw |=>
        context_regs.working == $past(instr_word[7:0]))
        else $error("literal not loaded");
    a_rlw_pc: assert property (rlw |=> program_counter == $past(stack_top))
        else $error("pc not loaded on literal return");
    a_pop_seq: assert property (rfi || rlw |=> s_pop)
        else $error("pop or busy timing wrong");
endmodule
bind rtiu_unit rtiu_properties u_props (.*);
`default_nettype wire

/* File: testbench/rtiu_unit_tb.sv */
/* Bench for the return instruction unit: random returns, queued notes.
   Assumes the bench models the core phase counter and the stack top. */
`timescale 1ns/1ps
`default_nettype none
module rtiu_unit_tb;
    typedef struct packed {
        logic [20:0] pc;
        rtiu_pkg::rtiu_context_type c;
        logic [1:0] gie;
        logic rfi;
        logic hp;
    } rtiu_note_type;
    logic ref_clk = 0, rst_b = 0, instr_valid = 0, low_context_active = 0;
    logic high_priority_active = 0, ctx_load = 0, stack_pop, busy;
    logic global_int_en_high, global_int_en_low, low_context_state, high_context_state;
    logic [1:0] phase = 0, gie_model = 0;
    logic [15:0] instr_word = 0;
    logic [20:0] stack_top = 0, program_counter;
    logic [127:0] r;
    rtiu_pkg::rtiu_context_type shadow_main = 0, shadow_low = 0, ctx_load_data = 0;
    rtiu_pkg::rtiu_context_type context_regs, m;
    rtiu_note_type q[$];
    int error_cnt = 0, cmp_count = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) phase <= rst_b ? phase + 2'h1 : 2'h0;
    rtiu_unit DUT (.*);
    task automatic cmp_ret(rtiu_note_type e);
        cmp_count++;
        if ({program_counter, context_regs} !== {e.pc, e.c}) begin
            error_cnt++;
            $display("unexpected %0t: return result %h", $time, {program_counter, context_regs});
        end
    endtask
    // The cleared state bit is the one of the priority level being left
    task automatic cmp_flags(rtiu_note_type e);
        logic left;
        left = e.hp ? high_context_state : low_context_state;
        cmp_count++;
        if ({global_int_en_high, global_int_en_low} !== e.gie || (e.rfi && left !== 1'b0)) begin
            error_cnt++;
            $display("unexpected %0t: enable or state bits wrong", $time);
        end
    endtask
    always @(posedge ref_clk) begin
        if (stack_pop === 1'b1 && q.size() == 0) begin
            error_cnt++;
            $display("unexpected %0t: pop with no return pending", $time);
        end else if (stack_pop === 1'b1) begin
            cmp_ret(q[0]);
            cmp_flags(q.pop_front());
        end
    end
    // Inputs go up at the edge before Q4 so the Q4 edge sees them settled
    task automatic ret(logic [15:0] w);
        logic lc;
        logic hp;
        logic rfi;
        for (int i = 0; i < 4 && phase !== 2'h2; i++) @(posedge ref_clk);
        if (phase !== 2'h2) error_cnt++;
        lc = 1'($urandom);
        hp = 1'($urandom);
        rfi = (w[15:1] == 15'h0008);
        r[20:0] = 21'($urandom);
        if (!rfi) m.working = w[7:0];
        else if (w[0]) m = lc ? shadow_low : shadow_main;
        if (rfi && hp) gie_model[1] = 1'b1;
        else if (rfi) gie_model[0] = 1'b1;
        q.push_back({r[20:0], m, gie_model, rfi, hp});
        instr_word <= w;
        instr_valid <= 1'b1;
        stack_top <= r[20:0];
        low_context_active <= lc;
        high_priority_active <= hp;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h7f697d0a));
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        r = {$urandom, $urandom, $urandom, $urandom};
        shadow_main <= r[103:0];
        shadow_low <= ~r[103:0];
        r = {$urandom, $urandom, $urandom, $urandom};
        m = r[103:0];
        ctx_load_data <= m;
        ctx_load <= 1'b1;
        @(posedge ref_clk);
        ctx_load <= 1'b0;
        for (int k = 0; k < 12; k++) ret(k % 3 == 0 ? {8'h0c, 8'($urandom)} : {15'h0008, k[0]});
        repeat (8) @(posedge ref_clk);
        if (q.size() != 0) error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
